/* File: include/bus_event_monitor_pkg.sv */
package bus_event_monitor_pkg;

   // --------------------------------------------------------------------
   // Sizes
   // --------------------------------------------------------------------
   localparam int unsigned NUM_COMPARATORS = 8;
   localparam int unsigned NUM_COUNTERS    = 4;
   localparam int unsigned BUS_WIDTH       = 32;
   localparam int unsigned COUNT_WIDTH     = 32;
   localparam int unsigned COMP_IDX_WIDTH  = 3;

   // --------------------------------------------------------------------
   // Comparison functions
   // --------------------------------------------------------------------
   typedef enum logic [2:0] {
      CMP_EQ = 3'h0,
      CMP_NE = 3'h1,
      CMP_GT = 3'h2,
      CMP_GE = 3'h3,
      CMP_LT = 3'h4,
      CMP_LE = 3'h5
   } compare_op_e;

   // --------------------------------------------------------------------
   // Counter modes
   // --------------------------------------------------------------------
   typedef enum logic [1:0] {
      CNT_IDLE     = 2'h0,
      CNT_EVENT    = 2'h1,
      CNT_DURATION = 2'h2
   } counter_state_e;

   localparam logic [COUNT_WIDTH-1:0] COUNT_RESET = 32'h0000_0000;
   localparam logic [COUNT_WIDTH-1:0] COUNT_ONE   = 32'h0000_0001;
   localparam logic [BUS_WIDTH-1:0]   BUS_ZERO    = 32'h0000_0000;

endpackage : bus_event_monitor_pkg

/* File: hw/bus_event_monitor.sv */
`timescale 1ns/100ps

module bus_event_monitor
   import bus_event_monitor_pkg::*;
#(
   parameter int unsigned NUM_COMP  = bus_event_monitor_pkg::NUM_COMPARATORS,
   parameter int unsigned NUM_CNT   = bus_event_monitor_pkg::NUM_COUNTERS,
   parameter int unsigned NUM_BUSES = 4
) (
   input  wire logic                                         sys_clk_in,
   input  wire logic                                         resetn_in,
   input  wire logic [NUM_BUSES*bus_event_monitor_pkg::BUS_WIDTH-1:0] bus_data_in,
   input  wire logic [NUM_BUSES-1:0]                         bus_valid_in,
   input  wire logic [NUM_COMP*2-1:0]                        comp_bus_sel_in,
   input  wire logic [NUM_COMP*bus_event_monitor_pkg::BUS_WIDTH-1:0]  comp_ref_in,
   input  wire logic [NUM_COMP*bus_event_monitor_pkg::BUS_WIDTH-1:0]  comp_mask_in,
   input  wire logic [NUM_COMP*3-1:0]                        comp_op_in,
   input  wire logic [NUM_COMP-1:0]                          comp_enable_in,
   input  wire logic [NUM_COMP-1:0]                          comp_int_enable_in,
   input  wire logic [NUM_COMP-1:0]                          comp_break_enable_in,
   input  wire logic [NUM_COMP-1:0]                          comp_watch_enable_in,
   input  wire logic [NUM_COMP-1:0]                          and_mask_in,
   input  wire logic [NUM_COMP-1:0]                          or_mask_in,
   input  wire logic                                         and_int_enable_in,
   input  wire logic                                         or_int_enable_in,
   input  wire logic [NUM_CNT-1:0]                           cnt_enable_in,
   input  wire logic [NUM_CNT-1:0]                           cnt_duration_mode_in,
   input  wire logic [NUM_CNT*4-1:0]                         cnt_start_sel_in,
   input  wire logic [NUM_CNT*4-1:0]                         cnt_stop_sel_in,
   input  wire logic [NUM_CNT-1:0]                           cnt_clear_in,
   input  wire logic                                         int_ack_in,
   output logic [NUM_COMP-1:0]                               comp_event_out,
   output logic                                              and_event_out,
   output logic                                              or_event_out,
   output logic                                              breakpoint_out,
   output logic                                              watchpoint_out,
   output logic                                              monitor_event_interrupt_out,
   output logic [NUM_COMP-1:0]                               int_cause_out,
   output logic                                              int_cause_and_out,
   output logic                                              int_cause_or_out,
   output logic [NUM_CNT*bus_event_monitor_pkg::COUNT_WIDTH-1:0]      cnt_value_out,
   output logic [NUM_CNT-1:0]                                cnt_running_out
);
   import bus_event_monitor_pkg::*;

   localparam int unsigned SEL_W = (NUM_BUSES > 1) ? $clog2(NUM_BUSES) : 1;
   localparam int unsigned NUM_SRC = NUM_COMP + 2;

   // Refuse sizes the fixed-width selectors cannot serve
   if (NUM_COMP < 2 || NUM_COMP > 8) begin : g_bad_comp
      $error("NUM_COMP must be 2..8");
   end
   if (NUM_BUSES < 1 || NUM_BUSES > 4) begin : g_bad_buses
      $error("NUM_BUSES must be 1..4 for a 2-bit selector");
   end
   if (NUM_CNT < 1 || NUM_SRC > 16) begin : g_bad_cnt
      $error("Counter event selector reaches at most 16 sources");
   end

   // ---------------------------------------------------------------------
   // Comparators
   // ---------------------------------------------------------------------
   logic [NUM_COMP-1:0] hit;

   always_comb begin
      for (int i = 0; i < NUM_COMP; i++) begin
         logic [1:0]           sel;
         logic [BUS_WIDTH-1:0] val;
         logic [BUS_WIDTH-1:0] refv;
         logic [BUS_WIDTH-1:0] msk;
         sel  = comp_bus_sel_in[i*2 +: 2];
         val  = BUS_ZERO;
         refv = comp_ref_in[i*BUS_WIDTH +: BUS_WIDTH];
         msk  = comp_mask_in[i*BUS_WIDTH +: BUS_WIDTH];
         hit[i] = 1'b0;
         if (32'(sel) < NUM_BUSES) begin
            val = bus_data_in[32'(sel)*BUS_WIDTH +: BUS_WIDTH] & ~msk;
            refv = refv & ~msk;
            case (compare_op_e'(comp_op_in[i*3 +: 3]))
               CMP_EQ:  hit[i] = (val == refv);
               CMP_NE:  hit[i] = (val != refv);
               CMP_GT:  hit[i] = (val >  refv);
               CMP_GE:  hit[i] = (val >= refv);
               CMP_LT:  hit[i] = (val <  refv);
               CMP_LE:  hit[i] = (val <= refv);
               default: hit[i] = 1'b0;
            endcase
            hit[i] = hit[i] & bus_valid_in[sel[SEL_W-1:0]] & comp_enable_in[i];
         end
      end
   end

   // ---------------------------------------------------------------------
   // Event combining and interrupt state
   // ---------------------------------------------------------------------
   logic [NUM_COMP-1:0] comp_event_reg,  comp_event_next;
   logic                and_event_reg,   and_event_next;
   logic                or_event_reg,    or_event_next;
   logic                brk_reg,         brk_next;
   logic                watch_reg,       watch_next;
   logic                irq_reg,         irq_next;
   logic [NUM_COMP-1:0] cause_reg,       cause_next;
   logic                cause_and_reg,   cause_and_next;
   logic                cause_or_reg,    cause_or_next;

   always_comb begin
      logic and_hit;
      logic or_hit;
      logic [NUM_COMP-1:0] int_src;
      logic fire;
      comp_event_next = hit;
      and_hit = (and_mask_in != '0) && ((hit & and_mask_in) == and_mask_in);
      or_hit  = |(hit & or_mask_in);
      and_event_next = and_hit;
      or_event_next  = or_hit;
      brk_next   = |(hit & comp_break_enable_in);
      watch_next = |(hit & comp_watch_enable_in);
      int_src = hit & comp_int_enable_in;
      fire = (|int_src) || (and_hit && and_int_enable_in) || (or_hit && or_int_enable_in);
      // pending until ack, new events win over the ack
      irq_next       = (irq_reg & ~int_ack_in) | fire;
      cause_next     = int_ack_in ? '0 : cause_reg;
      cause_and_next = cause_and_reg & ~int_ack_in;
      cause_or_next  = cause_or_reg & ~int_ack_in;
      // cause shows each firing unit, so both of an OR pair are visible
      if (or_hit && or_int_enable_in)
         cause_next = cause_next | (hit & or_mask_in);
      if (and_hit && and_int_enable_in)
         cause_next = cause_next | (hit & and_mask_in);
      cause_next     = cause_next | int_src;
      cause_and_next = cause_and_next | (and_hit & and_int_enable_in);
      cause_or_next  = cause_or_next | (or_hit & or_int_enable_in);
   end

   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         comp_event_reg <= '0;
         and_event_reg  <= 1'b0;
         or_event_reg   <= 1'b0;
         brk_reg        <= 1'b0;
         watch_reg      <= 1'b0;
         irq_reg        <= 1'b0;
         cause_reg      <= '0;
         cause_and_reg  <= 1'b0;
         cause_or_reg   <= 1'b0;
      end else begin
         comp_event_reg <= comp_event_next;
         and_event_reg  <= and_event_next;
         or_event_reg   <= or_event_next;
         brk_reg        <= brk_next;
         watch_reg      <= watch_next;
         irq_reg        <= irq_next;
         cause_reg      <= cause_next;
         cause_and_reg  <= cause_and_next;
         cause_or_reg   <= cause_or_next;
      end
   end

   assign comp_event_out              = comp_event_reg;
   assign and_event_out               = and_event_reg;
   assign or_event_out                = or_event_reg;
   assign breakpoint_out              = brk_reg;
   assign watchpoint_out              = watch_reg;
   assign monitor_event_interrupt_out = irq_reg;
   assign int_cause_out               = cause_reg;
   assign int_cause_and_out           = cause_and_reg;
   assign int_cause_or_out            = cause_or_reg;

   // ---------------------------------------------------------------------
   // Event counters
   // ---------------------------------------------------------------------
   // Counters see the registered events, one cycle behind the comparators
   logic [15:0] src_vec;
   always_comb begin
      src_vec = '0;
      src_vec[NUM_COMP-1:0] = comp_event_reg;
      src_vec[NUM_COMP]     = and_event_reg;
      src_vec[NUM_COMP+1]   = or_event_reg;
   end

   counter_state_e            cst_reg [NUM_CNT];
   counter_state_e            cst_next[NUM_CNT];
   logic [COUNT_WIDTH-1:0]    cval_reg [NUM_CNT];
   logic [COUNT_WIDTH-1:0]    cval_next[NUM_CNT];

   always_comb begin
      for (int c = 0; c < NUM_CNT; c++) begin
         logic st;
         logic sp;
         st = src_vec[cnt_start_sel_in[c*4 +: 4]];
         sp = src_vec[cnt_stop_sel_in[c*4 +: 4]];
         cst_next[c]  = cst_reg[c];
         cval_next[c] = cval_reg[c];
         case (cst_reg[c])
            CNT_IDLE: begin
               if (cnt_enable_in[c] && cnt_duration_mode_in[c] && st) begin
                  cst_next[c]  = CNT_DURATION;
                  cval_next[c] = COUNT_RESET;
               end else if (cnt_enable_in[c] && !cnt_duration_mode_in[c]) begin
                  cst_next[c] = CNT_EVENT;
               end
            end
            CNT_EVENT: begin
               if (!cnt_enable_in[c] || cnt_duration_mode_in[c])
                  cst_next[c] = CNT_IDLE;
               else if (st)
                  cval_next[c] = cval_reg[c] + COUNT_ONE;
            end
            CNT_DURATION: begin
               if (!cnt_enable_in[c] || sp)
                  cst_next[c] = CNT_IDLE;
               else
                  cval_next[c] = cval_reg[c] + COUNT_ONE;
            end
            default: cst_next[c] = CNT_IDLE;
         endcase
         if (cnt_clear_in[c]) begin
            cval_next[c] = COUNT_RESET;
            cst_next[c]  = CNT_IDLE;
         end
      end
   end

   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         for (int c = 0; c < NUM_CNT; c++) begin
            cst_reg[c]  <= CNT_IDLE;
            cval_reg[c] <= COUNT_RESET;
         end
      end else begin
         for (int c = 0; c < NUM_CNT; c++) begin
            cst_reg[c]  <= cst_next[c];
            cval_reg[c] <= cval_next[c];
         end
      end
   end

   always_comb begin
      for (int c = 0; c < NUM_CNT; c++) begin
         cnt_value_out[c*COUNT_WIDTH +: COUNT_WIDTH] = cval_reg[c];
         cnt_running_out[c] = (cst_reg[c] != CNT_IDLE);
      end
   end

endmodule : bus_event_monitor

/* File: dv/bus_event_monitor_asserts.sv */
`timescale 1ns/100ps
module bus_event_monitor_asserts
   import bus_event_monitor_pkg::*;
#(
   parameter int unsigned NUM_COMP = 8,
   parameter int unsigned NUM_CNT  = 4
) (
   input wire logic                               sys_clk_in,
   input wire logic                               resetn_in,
   input wire logic [NUM_COMP-1:0]                comp_enable_in,
   input wire logic [NUM_COMP-1:0]                comp_int_enable_in,
   input wire logic [NUM_COMP-1:0]                comp_break_enable_in,
   input wire logic [NUM_COMP-1:0]                and_mask_in,
   input wire logic [NUM_COMP-1:0]                or_mask_in,
   input wire logic [NUM_CNT-1:0]                 cnt_enable_in,
   input wire logic [NUM_CNT-1:0]                 cnt_clear_in,
   input wire logic                               int_ack_in,
   input wire logic [NUM_COMP-1:0]                comp_event_out,
   input wire logic                               and_event_out,
   input wire logic                               or_event_out,
   input wire logic                               breakpoint_out,
   input wire logic                               monitor_event_interrupt_out,
   input wire logic [NUM_COMP-1:0]                int_cause_out,
   input wire logic [NUM_CNT*COUNT_WIDTH-1:0]     cnt_value_out,
   input wire logic [NUM_CNT-1:0]                 cnt_running_out
);
   // ----------------------------------------
   // Event, interrupt and counter relations
   // ----------------------------------------
   default clocking mon_cb @(posedge sys_clk_in); endclocking
   default disable iff (!resetn_in);

   a_and_merge: assert property (
      and_event_out == ($past(and_mask_in) != '0
         && (comp_event_out & $past(and_mask_in)) == $past(and_mask_in)))
      else $error("and event disagrees with unit events");
   a_or_merge: assert property (
      or_event_out == |(comp_event_out & $past(or_mask_in)))
      else $error("or event disagrees with unit events");
   a_break_route: assert property (
      breakpoint_out == |(comp_event_out & $past(comp_break_enable_in)))
      else $error("breakpoint disagrees with unit events");
   a_unit_gate: assert property (
      (comp_event_out & ~$past(comp_enable_in)) == '0)
      else $error("disabled unit raised an event");
   a_irq_raise: assert property (
      |(comp_event_out & $past(comp_int_enable_in)) |-> monitor_event_interrupt_out
         && (comp_event_out & $past(comp_int_enable_in) & ~int_cause_out) == '0)
      else $error("enabled hit without interrupt or cause");
   a_irq_hold: assert property (
      monitor_event_interrupt_out && !int_ack_in |=> monitor_event_interrupt_out
         && (int_cause_out & $past(int_cause_out)) == $past(int_cause_out))
      else $error("interrupt or cause dropped without ack");
   a_ack_clear: assert property (
      int_ack_in ##1 (comp_event_out == '0 && !and_event_out && !or_event_out)
         |-> !monitor_event_interrupt_out && int_cause_out == '0)
      else $error("ack did not clear interrupt");
   a_cnt_hold: assert property (
      $past(!cnt_enable_in[0] && !cnt_clear_in[0])
         |-> $stable(cnt_value_out[31:0]) && !cnt_running_out[0])
      else $error("disabled counter changed");

   cover property (or_event_out && monitor_event_interrupt_out);
   cover property (and_event_out);
   cover property (|cnt_running_out);
endmodule : bus_event_monitor_asserts

/* File: dv/core_bus_model.sv */
`timescale 1ns/100ps
module core_bus_model
   import bus_event_monitor_pkg::*;
(
   input  wire logic         sys_clk_in,
   input  wire logic [127:0] req_data_in,
   input  wire logic [3:0]   req_valid_in,
   output logic      [127:0] bus_data_out,
   output logic      [3:0]   bus_valid_out
);
   // ----------------------------------------
   // Core buses
   // ----------------------------------------
   logic [BUS_WIDTH-1:0] noise_reg = BUS_ZERO;
   // Idle buses churn so a stale value can never fake a match
   always @(posedge sys_clk_in) noise_reg <= noise_reg + 32'h3c5a_9617;
   always_comb begin
      for (int b = 0; b < 4; b++)
         bus_data_out[b*32+:32] = req_valid_in[b] ? req_data_in[b*32+:32] : noise_reg ^ 32'(b);
      bus_valid_out = req_valid_in;
   end
endmodule : core_bus_model

/* File: dv/tb.sv */
`timescale 1ns/100ps
module tb;
   import bus_event_monitor_pkg::*;
   // ----------------------------------------
   // Stimulus and expectation state
   // ----------------------------------------
   logic         sys_clk_in = 1'b0, resetn_in = 1'b0, int_ack_in = 1'b0;
   logic         aie, oie, ea, eo, xi, xa, xo, and_ev, or_ev, bp, wp, irq, c_and, c_or;
   logic [31:0]  dat[4], rf[8], mk[8], xv[4];
   logic [2:0]   op[8];
   logic [1:0]   sl[8], st[4];
   logic [3:0]   ss[4], ps[4], vl, cen, ccl, crun, bvl, xr;
   logic [3:0]   cdm = 4'hc;
   logic [7:0]   en, ie, be, we, am, om, e, xc, ev, cause;
   logic [15:0]  fsel, fss, fps;
   logic [23:0]  fop;
   logic [127:0] bdat, bus, cval;
   logic [255:0] fref, fmsk;
   int           err_count = 0, n_tests = 0;

   always #4 sys_clk_in = ~sys_clk_in;
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         fsel[i*2+:2] = sl[i];
         fref[i*32+:32] = rf[i];
         fmsk[i*32+:32] = mk[i];
         fop[i*3+:3] = op[i];
      end
      for (int c = 0; c < 4; c++) begin
         bdat[c*32+:32] = dat[c];
         fss[c*4+:4] = ss[c];
         fps[c*4+:4] = ps[c];
      end
   end

   core_bus_model core (.sys_clk_in, .req_data_in(bdat), .req_valid_in(vl),
      .bus_data_out(bus), .bus_valid_out(bvl));
   bus_event_monitor dut (.sys_clk_in, .resetn_in, .bus_data_in(bus), .bus_valid_in(bvl),
      .comp_bus_sel_in(fsel), .comp_ref_in(fref), .comp_mask_in(fmsk), .comp_op_in(fop),
      .comp_enable_in(en), .comp_int_enable_in(ie), .comp_break_enable_in(be),
      .comp_watch_enable_in(we), .and_mask_in(am), .or_mask_in(om), .and_int_enable_in(aie),
      .or_int_enable_in(oie), .cnt_enable_in(cen), .cnt_duration_mode_in(cdm),
      .cnt_start_sel_in(fss), .cnt_stop_sel_in(fps), .cnt_clear_in(ccl), .int_ack_in,
      .comp_event_out(ev), .and_event_out(and_ev), .or_event_out(or_ev), .breakpoint_out(bp),
      .watchpoint_out(wp), .monitor_event_interrupt_out(irq), .int_cause_out(cause),
      .int_cause_and_out(c_and), .int_cause_or_out(c_or), .cnt_value_out(cval),
      .cnt_running_out(crun));

   function automatic logic hit(input int i);
      logic [31:0] a, r;
      a = dat[sl[i]] & ~mk[i];
      r = rf[i] & ~mk[i];
      if (!en[i] || !vl[sl[i]]) return 1'b0;
      case (op[i])
         3'h0: return a == r;
         3'h1: return a != r;
         3'h2: return a > r;
         3'h3: return a >= r;
         3'h4: return a < r;
         3'h5: return a <= r;
         default: return 1'b0;
      endcase
   endfunction : hit

   function automatic logic src(input logic [3:0] s);
      return s == 4'h9 ? eo : s == 4'h8 ? ea : e[s[2:0]];
   endfunction : src

   task automatic chk(input string nm, input logic [127:0] x, input logic [127:0] g);
      n_tests++;
      if (g !== x) begin
         $display("MISMATCH %s expected %h seen %h", nm, x, g);
         err_count++;
      end
   endtask : chk

   // ----------------------------------------
   // One clock of model and comparison
   // ----------------------------------------
   task automatic step();
      logic [7:0] n, s;
      logic       na, no;
      // Counters see the events already on the outputs
      for (int c = 0; c < 4; c++) begin
         if (ccl[c]) begin
            st[c] = 2'h0;
            xv[c] = '0;
         end else if (!cen[c]) st[c] = 2'h0;
         else if (st[c] == 2'h1 && cdm[c]) st[c] = 2'h0;
         else if (st[c] == 2'h1) xv[c] += 32'(src(ss[c]));
         else if (st[c] == 2'h2) begin
            if (src(ps[c])) st[c] = 2'h0;
            else xv[c] += 32'h1;
         end else if (!cdm[c]) st[c] = 2'h1;
         else if (src(ss[c])) begin
            st[c] = 2'h2;
            xv[c] = '0;
         end
         xr[c] = st[c] != 2'h0;
      end
      for (int i = 0; i < 8; i++) n[i] = hit(i);
      na = am != '0 && (n & am) == am;
      no = |(n & om);
      s = (n & ie) | (na && aie ? n & am : 8'h0) | (no && oie ? n & om : 8'h0);
      xc = s | (int_ack_in ? 8'h0 : xc);
      xi = |s | (xi & ~int_ack_in);
      xa = (na & aie) | (xa & ~int_ack_in);
      xo = (no & oie) | (xo & ~int_ack_in);
      {e, ea, eo} = {n, na, no};
      @(negedge sys_clk_in);
      chk("comp_event", e, ev);
      chk("and_or_event", {ea, eo}, {and_ev, or_ev});
      chk("break_watch", {|(e & be), |(e & we)}, {bp, wp});
      chk("irq_cause", {xi, xa, xo, xc}, {irq, c_and, c_or, cause});
      chk("counters", {xr, xv[3], xv[2], xv[1], xv[0]}, {crun, cval});
   endtask : step

   task automatic rnd();
      foreach (dat[b]) begin
         dat[b] = $urandom_range(15);
         ss[b] = 4'($urandom_range(9));
         ps[b] = 4'($urandom_range(9));
      end
      foreach (rf[i]) begin
         rf[i] = $urandom_range(15);
         mk[i] = $urandom_range(3);
         op[i] = 3'($urandom);
         sl[i] = 2'($urandom);
      end
      {vl, en, ie, be, we, om, aie, oie} = 46'({$urandom, $urandom});
      am = 8'($urandom & $urandom & $urandom);
      cen = 4'($urandom | $urandom);
      ccl = $urandom_range(15) == 0 ? 4'($urandom) : 4'h0;
      int_ack_in = $urandom_range(7) == 0;
      // Rare mode flips reach the event-to-idle exit
      if ($urandom_range(63) == 0) cdm = 4'($urandom);
   endtask : rnd

   task automatic summarize();
      if (err_count == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : summarize

   initial begin
      void'($urandom(22));
      {en, ie, be, we, am, om, e, xc, vl, cen, ccl, aie, oie, ea, eo, xi, xa, xo} = '0;
      foreach (rf[i]) {rf[i], mk[i], op[i], sl[i]} = '0;
      foreach (dat[c]) {dat[c], xv[c], st[c], ss[c], ps[c]} = '0;
      repeat (20) @(negedge sys_clk_in);
      resetn_in = 1'b1;
      // Redundant pair on one bus merged by OR
      {en, om, oie, vl, dat[1]} = {8'h24, 8'h24, 1'b1, 4'hf, 32'h5};
      foreach (sl[i]) {sl[i], rf[i]} = {2'h1, 32'h5};
      step();
      rf[5] = 32'h6;
      int_ack_in = 1'b1;
      step();
      en = 8'h0;
      step();
      repeat (2) begin
         repeat (1500) begin
            rnd();
            step();
         end
         // Mid-run reset: all state clears although inputs still match
         resetn_in = 1'b0;
         @(negedge sys_clk_in);
         chk("reset_events", '0, {ev, and_ev, or_ev, bp, wp, irq, cause, c_and, c_or});
         chk("reset_counters", '0, {crun, cval});
         {e, ea, eo, xi, xa, xo, xc} = '0;
         foreach (st[c]) {st[c], xv[c]} = '0;
         resetn_in = 1'b1;
      end
      summarize();
   end

   // Tests need about 3030 cycles; a hang is cut well beyond that
   initial begin
      repeat (20000) @(posedge sys_clk_in);
      err_count++;
      summarize();
   end
endmodule : tb

bind bus_event_monitor bus_event_monitor_asserts #(.NUM_COMP(NUM_COMP), .NUM_CNT(NUM_CNT))
   checker_i (.sys_clk_in, .resetn_in, .comp_enable_in, .comp_int_enable_in,
   .comp_break_enable_in, .and_mask_in, .or_mask_in, .cnt_enable_in, .cnt_clear_in,
   .int_ack_in, .comp_event_out, .and_event_out, .or_event_out, .breakpoint_out,
   .monitor_event_interrupt_out, .int_cause_out, .cnt_value_out, .cnt_running_out);
